// ==== src/wwdt_top.sv ====
// watchdog timer with axi4-lite register access
`timescale 1ns/10ps
module wwdt_top #(
   parameter int PRESC_DIV = wwdt_pkg::PRESC_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       SRST,
   input  wire logic                       HALT_EXEC,
   output logic                            WDG_RST_REQ,
   output logic                            WDG_ARMED,
   input  wire logic                       AWVALID,
   output logic                            AWREADY,
   input  wire logic [wwdt_pkg::AXI_AW-1:0] AWADDR,
   input  wire logic                       WVALID,
   output logic                            WREADY,
   input  wire logic [31:0]                WDATA,
   input  wire logic [3:0]                 WSTRB,
   output logic                            BVALID,
   input  wire logic                       BREADY,
   output logic [1:0]                      BRESP,
   input  wire logic                       ARVALID,
   output logic                            ARREADY,
   input  wire logic [wwdt_pkg::AXI_AW-1:0] ARADDR,
   output logic                            RVALID,
   input  wire logic                       RREADY,
   output logic [31:0]                     RDATA,
   output logic [1:0]                      RRESP
);

   typedef struct packed {
      logic        armed;
      logic [6:0]  cnt;
      logic        hw_opt;
      logic        halt_opt;
      logic [1:0]  tb;
      logic        rst_req;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } wwdt_state_s;

   wwdt_state_s         q;
   wwdt_state_s         d;

   wwdt_tick_if         tk ();

   logic                wr_go;
   logic                rd_go;
   wwdt_pkg::wwdt_reg_e wsel;
   wwdt_pkg::wwdt_reg_e rsel;
   logic                wr_ctrl;
   logic                wr_cfg;
   logic                arm_eff;
   logic                arm_new;
   logic                wrap_ev;
   logic                force_ev;
   logic                halt_ev;
   logic [31:0]         t_min;
   logic [31:0]         t_max;
   logic [31:0]         rd_val;

   wwdt_presc #(
      .DIV  (PRESC_DIV)
   ) u_presc (
      .clk  (CLK),
      .srst (SRST),
      .tk   (tk.src)
   );

   // both address and data must be offered before either is taken;
   // the master holds both, so taking them together is legal
   assign wr_go   = AWVALID & WVALID & ~q.bvalid;
   assign rd_go   = ARVALID & ~q.rvalid;
   assign AWREADY = wr_go;
   assign WREADY  = wr_go;
   assign ARREADY = ~q.rvalid;

   assign wsel    = wwdt_pkg::wwdt_decode(AWADDR);
   assign rsel    = wwdt_pkg::wwdt_decode(ARADDR);

   // only the low byte lane carries register bits
   assign wr_ctrl = wr_go & WSTRB[0] & (wsel == wwdt_pkg::REG_CTRL);
   assign wr_cfg  = wr_go & WSTRB[0] & (wsel == wwdt_pkg::REG_CFG);

   // hardware option keeps the watchdog active whatever the arm bit
   assign arm_eff = q.armed | q.hw_opt;
   assign arm_new = arm_eff | WDATA[wwdt_pkg::ARM_BIT];

   // a write in the tick cycle wins: the loaded value stands and the
   // decrement of that tick is lost, one count of extra margin
   assign wrap_ev = tk.tick & ~wr_ctrl & arm_eff
                  & (q.cnt == wwdt_pkg::WRAP_FROM);

   // clearing the top bit while armed is the software reset path
   assign force_ev = wr_ctrl & arm_new
                   & ~WDATA[wwdt_pkg::TOP_BIT];

   assign halt_ev = HALT_EXEC & arm_eff & q.halt_opt;

   // bounds of the timeout for the current, decrementing count and timebase
   assign t_min = wwdt_pkg::wwdt_timeout(q.cnt[5:0], q.tb,
                                         1'b0);
   assign t_max = wwdt_pkg::wwdt_timeout(q.cnt[5:0], q.tb,
                                         1'b1);

   always_comb begin
      rd_val = 32'h0;
      case (rsel)
         wwdt_pkg::REG_CTRL: begin
            rd_val[7:0] = {q.armed, q.cnt};
         end
         wwdt_pkg::REG_CFG: begin
            rd_val[wwdt_pkg::CFG_HW_BIT]   = q.hw_opt;
            rd_val[wwdt_pkg::CFG_HALT_BIT] = q.halt_opt;
            rd_val[wwdt_pkg::CFG_TB_LSB +: 2] = q.tb;
            rd_val[wwdt_pkg::CFG_ARM_BIT]  = arm_eff;
         end
         wwdt_pkg::REG_TMIN: begin
            rd_val = t_min;
         end
         wwdt_pkg::REG_TMAX: begin
            rd_val = t_max;
         end
         default: begin
            rd_val = 32'h0;
         end
      endcase
   end

   always_comb begin
      d         = q;
      d.rst_req = 1'b0;

      // counter: load on write, otherwise free-running decrement
      if (wr_ctrl) begin
         d.cnt = WDATA[wwdt_pkg::TOP_BIT:0];
      end else if (tk.tick) begin
         d.cnt = q.cnt - 1'b1;
      end

      // arm bit is set-only; a zero written there is ignored
      if (wr_ctrl && WDATA[wwdt_pkg::ARM_BIT]) begin
         d.armed = 1'b1;
      end

      if (wr_cfg) begin
         // hardware option behaves as non-volatile: only reset clears it
         d.hw_opt   = q.hw_opt | WDATA[wwdt_pkg::CFG_HW_BIT];
         d.halt_opt = WDATA[wwdt_pkg::CFG_HALT_BIT];
         d.tb       = WDATA[wwdt_pkg::CFG_TB_LSB +: 2];
      end

      // one pulse per event; system reset logic stretches it to the
      // external pin width and clears this block in turn
      d.rst_req = wrap_ev | force_ev | halt_ev;

      // write response
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp  = (wsel == wwdt_pkg::REG_NONE)
                  ? wwdt_pkg::RESP_SLVERR : wwdt_pkg::RESP_OKAY;
      end else if (q.bvalid && BREADY) begin
         d.bvalid = 1'b0;
      end

      // read response
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_val;
         d.rresp  = (rsel == wwdt_pkg::REG_NONE)
                  ? wwdt_pkg::RESP_SLVERR : wwdt_pkg::RESP_OKAY;
      end else if (q.rvalid && RREADY) begin
         d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         q          <= '0;
         q.armed    <= wwdt_pkg::CTRL_RST[wwdt_pkg::ARM_BIT];
         q.cnt      <= wwdt_pkg::CTRL_RST[wwdt_pkg::TOP_BIT:0];
      end else begin
         q <= d;
      end
   end

   assign WDG_RST_REQ = q.rst_req;
   assign WDG_ARMED   = q.armed | q.hw_opt;
   assign BVALID      = q.bvalid;
   assign BRESP       = q.bresp;
   assign RVALID      = q.rvalid;
   assign RDATA       = q.rdata;
   assign RRESP       = q.rresp;

endmodule

// ==== shared/wwdt_pkg.sv ====
// constants, types and helper functions of the watchdog timer
// Behaviour
// - count decrements once per 16384 clocks
// - low six count bits set timeout
// - armed wrap 40h to 3Fh requests reset
// - counter runs even when not armed
// - disarmed at reset, only reset disarms
// - arm set, top clear forces reset
// - armed halt instruction causes reset
// - options: hardware watchdog, halt reset select
// - timeout spans minimum to maximum, unknown phase
// - timebase select picks coefficient pair
// - minimum timeout formula with correction terms
// - maximum timeout formula with correction terms
// - all divisions truncate toward zero
// - control byte resets to 7Fh
// - arm bit 7, counter bits 6..0
package wwdt_pkg;

   localparam int          AXI_AW     = 12;
   localparam logic [7:0]  CTRL_IDX   = 8'h2a;
   localparam logic [7:0]  CFG_IDX    = 8'h2b;
   localparam logic [7:0]  TMIN_IDX   = 8'h2c;
   localparam logic [7:0]  TMAX_IDX   = 8'h2d;

   localparam logic [7:0]  CTRL_RST   = 8'h7f;
   localparam int          ARM_BIT    = 7;
   localparam int          TOP_BIT    = 6;
   localparam logic [6:0]  WRAP_FROM  = 7'h40;

   localparam int          CFG_HW_BIT   = 0;
   localparam int          CFG_HALT_BIT = 1;
   localparam int          CFG_TB_LSB   = 2;
   localparam int          CFG_ARM_BIT  = 4;

   localparam int          PRESC_CYC  = 16384;

   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   localparam logic [31:0] PER_COUNT  = 32'h0000_4000;
   localparam logic [31:0] MIN_ADD    = 32'h0000_0080;
   localparam logic [31:0] CORR_ADD   = 32'h0000_00c0;
   localparam logic [31:0] STEP_MUL   = 32'h0000_0040;
   localparam logic [31:0] QUARTER    = 32'h0000_0004;

   typedef enum logic [2:0] {
      REG_NONE, REG_CTRL, REG_CFG, REG_TMIN, REG_TMAX
   } wwdt_reg_e;

   // coefficient pairs per timebase: 2ms, 4ms, 10ms, 25ms
   function automatic logic [31:0] wwdt_coef_a(input logic [1:0] tb);
      case (tb)
         2'h0:    wwdt_coef_a = 32'h0000_0004;
         2'h1:    wwdt_coef_a = 32'h0000_0008;
         2'h2:    wwdt_coef_a = 32'h0000_0014;
         default: wwdt_coef_a = 32'h0000_0031;
      endcase
   endfunction

   function automatic logic [31:0] wwdt_coef_b(input logic [1:0] tb);
      case (tb)
         2'h0:    wwdt_coef_b = 32'h0000_003b;
         2'h1:    wwdt_coef_b = 32'h0000_0035;
         2'h2:    wwdt_coef_b = 32'h0000_0023;
         default: wwdt_coef_b = 32'h0000_0036;
      endcase
   endfunction

   // timeout in oscillator periods; integer division truncates
   function automatic logic [31:0] wwdt_timeout(
      input logic [5:0] cnt,
      input logic [1:0] tb,
      input logic       is_max);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic [31:0] q;
      logic [31:0] base;
      logic        lin;
      a    = wwdt_coef_a(tb);
      b    = wwdt_coef_b(tb);
      c    = {26'h0, cnt};
      q    = (QUARTER * c) / a;
      base = is_max ? PER_COUNT
                    : (b + MIN_ADD) * STEP_MUL;
      lin  = is_max ? (c <= a / QUARTER)
                    : (c <  a / QUARTER);
      if (lin) begin
         wwdt_timeout = base + PER_COUNT * c;
      end else begin
         wwdt_timeout = base + PER_COUNT * (c - q)
                      + (CORR_ADD + b) * STEP_MUL * q;
      end
   endfunction

   function automatic wwdt_reg_e wwdt_decode(
      input logic [AXI_AW-1:0] addr);
      wwdt_decode = REG_NONE;
      if (addr[AXI_AW-1:10] == '0 && addr[1:0] == 2'h0) begin
         if (addr[9:2] == CTRL_IDX)      wwdt_decode = REG_CTRL;
         else if (addr[9:2] == CFG_IDX)  wwdt_decode = REG_CFG;
         else if (addr[9:2] == TMIN_IDX) wwdt_decode = REG_TMIN;
         else if (addr[9:2] == TMAX_IDX) wwdt_decode = REG_TMAX;
      end
   endfunction

endpackage

// ==== shared/wwdt_tick_if.sv ====
// carrier of the prescaler tick between watchdog modules
`timescale 1ns/10ps
interface wwdt_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface

// ==== src/wwdt_presc.sv ====
// free-running prescaler that paces the watchdog counter
`timescale 1ns/10ps
module wwdt_presc #(
   parameter int DIV = wwdt_pkg::PRESC_CYC
) (
   input  wire logic     clk,
   input  wire logic     srst,
   wwdt_tick_if.src      tk
);
   typedef struct packed {
      logic [$clog2(DIV)-1:0] cnt;
      logic                   tick;
   } wwdt_presc_s;

   localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

   wwdt_presc_s q;
   wwdt_presc_s d;

   // phase is never reloaded by software writes, so the first
   // decrement after a write lands anywhere in one period
   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (q.cnt == LAST) begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;
endmodule

// ==== dv/wwdt_chk.sv ====
// port assertions for the watchdog timer
`timescale 1ns/10ps
module wwdt_chk #(
   parameter int PRESC_DIV = wwdt_pkg::PRESC_CYC
) (
   input wire logic                        CLK,
   input wire logic                        SRST,
   input wire logic                        HALT_EXEC,
   input wire logic                        WDG_RST_REQ,
   input wire logic                        WDG_ARMED,
   input wire logic                        AWVALID,
   input wire logic [wwdt_pkg::AXI_AW-1:0] AWADDR,
   input wire logic                        WVALID,
   input wire logic [31:0]                 WDATA,
   input wire logic [3:0]                  WSTRB,
   input wire logic                        BVALID,
   input wire logic                        ARVALID,
   input wire logic                        RVALID
);
   typedef struct packed { logic [31:0] ph; } wwdt_chk_s;
   wwdt_chk_s st_q;
   wwdt_chk_s st_d;
   logic      wr;
   logic      wc;
   assign wr = AWVALID && WVALID && !BVALID;
   assign wc = wr && WSTRB[0] && AWADDR == {2'h0, wwdt_pkg::CTRL_IDX, 2'h0};
   // mirror of the prescaler phase, restarted by reset like the real one
   always_comb begin
      st_d = st_q;
      st_d.ph = (SRST || st_q.ph == 32'(PRESC_DIV - 1)) ? '0 : st_q.ph + 32'h1;
   end
   always_ff @(posedge CLK) begin
      st_q <= st_d;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   a_write_answer:
      assert property (wr |=> BVALID) else $error("write not answered");
   a_read_answer:
      assert property (ARVALID && !RVALID |=> RVALID)
      else $error("read not answered");
   a_req_single:
      assert property (WDG_RST_REQ |=> !WDG_RST_REQ)
      else $error("reset request longer than one cycle");
   a_arm_sticky:
      assert property (WDG_ARMED |=> WDG_ARMED) else $error("armed state lost");
   a_arm_on_write:
      assert property (wc && WDATA[7] |=> WDG_ARMED)
      else $error("arm bit write ignored");
   a_force_reset:
      assert property (wc && WDATA[7:6] == 2'h2 |=> WDG_RST_REQ)
      else $error("forced reset missing");
   a_quiet_unarmed:
      assert property (!WDG_ARMED && !wr |=> !WDG_RST_REQ)
      else $error("reset request while disarmed");
   // the request flop lags the tick by one cycle, so the phase reads one
   a_tick_phase:
      assert property (WDG_RST_REQ && !$past(wr) && !$past(HALT_EXEC)
                       |-> st_q.ph == 32'h1)
      else $error("timeout reset off the prescaler tick");
endmodule
bind wwdt_top wwdt_chk #(.PRESC_DIV(PRESC_DIV)) u_chk (
   .CLK(CLK), .SRST(SRST), .HALT_EXEC(HALT_EXEC), .WDG_RST_REQ(WDG_RST_REQ),
   .WDG_ARMED(WDG_ARMED), .AWVALID(AWVALID), .AWADDR(AWADDR),
   .WVALID(WVALID), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
   .ARVALID(ARVALID), .RVALID(RVALID));

// ==== dv/wwdt_tb_top.sv ====
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
module wwdt_tb_top;
   localparam int DIV = 64;
   localparam logic [11:0] A_CTRL = {2'h0, wwdt_pkg::CTRL_IDX, 2'h0};
   localparam logic [11:0] A_CFG  = {2'h0, wwdt_pkg::CFG_IDX, 2'h0};
   localparam logic [11:0] A_TMIN = {2'h0, wwdt_pkg::TMIN_IDX, 2'h0};
   localparam logic [11:0] A_TMAX = {2'h0, wwdt_pkg::TMAX_IDX, 2'h0};
   logic        clk = 1'b0, srst = 1'b1, halt = 1'b0, req, armed;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready = 1'b1, rready = 1'b1;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, v, v2, tmin, tmax;
   logic [3:0]  wstrb = 4'h0;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  cv [4] = '{8'h40, 8'h42, 8'h45, 8'h4d};
   int          miscompares = 0, total_checks = 0, req_cnt = 0, n;

   wwdt_top #(.PRESC_DIV(DIV)) dut (
      .CLK(clk), .SRST(srst), .HALT_EXEC(halt), .WDG_RST_REQ(req),
      .WDG_ARMED(armed), .AWVALID(awvalid), .AWREADY(awready),
      .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
      .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
      .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
      .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp));

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (req) req_cnt++;
   end

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ready lines stay high, so every answer is taken the edge it shows
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic aw, w;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      aw = 1'b1;
      w = 1'b1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      r = bresp;
   endtask

   task automatic rd(input logic [11:0] a);
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      v = rdata;
      r = rresp;
   endtask

   task automatic rst();
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_halt();
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   function automatic logic [31:0] tmo(input int c, input int tb,
                                       input bit mx);
      int a, b, q;
      a = (tb == 0) ? 4 : (tb == 1) ? 8 : (tb == 2) ? 20 : 49;
      b = (tb == 0) ? 59 : (tb == 1) ? 53 : (tb == 2) ? 35 : 54;
      q = 4 * c / a;
      if (mx ? c <= a / 4 : c < a / 4) q = 0;
      tmo = 32'((mx ? 16384 : (b + 128) * 64) + 16384 * (c - q)
                + (192 + b) * 64 * q);
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(A_CTRL);
      check("ctrl_reset", v, 32'h7f);
      check("armed_reset", {31'h0, armed}, 32'h0);
      rd(12'h0fc);
      check("rd_unmapped", {30'h0, r}, 32'h2);
      wr(12'h0fc, 32'h0, 4'hf);
      check("wr_unmapped", {30'h0, r}, 32'h2);
      wr(A_CTRL, 32'h80, 4'he);
      check("strobe_off", {31'h0, armed}, 32'h0);
      wr(A_CTRL, 32'h42, 4'h1);
      repeat (4 * DIV) @(posedge clk);
      rd(A_CTRL);
      check("ctrl_decr", {31'h0, v >= 32'h3d && v <= 32'h3e}, 32'h1);
      check("no_req_unarmed", 32'(req_cnt), 32'h0);
      for (int tb = 0; tb < 4; tb++) begin
         wr(A_CFG, 32'(tb << 2), 4'hf);
         rd(A_CFG);
         check("cfg_tb", v, 32'(tb << 2));
         for (int i = 0; i < 4; i++) begin
            wr(A_CTRL, {24'h0, cv[i]}, 4'hf);
            // a tick between the reads would pair the wrong count
            do begin
               rd(A_CTRL);
               v2 = v;
               rd(A_TMIN);
               tmin = v;
               rd(A_TMAX);
               tmax = v;
               rd(A_CTRL);
            end while (v !== v2);
            check("tmin", tmin, tmo(int'(v[5:0]), tb, 1'b0));
            check("tmax", tmax, tmo(int'(v[5:0]), tb, 1'b1));
         end
      end
      wr(A_CFG, 32'h2, 4'hf);
      pulse_halt();
      check("halt_unarmed", 32'(req_cnt), 32'h0);
      wr(A_CTRL, 32'hc1, 4'hf);
      check("armed", {31'h0, armed}, 32'h1);
      // refresh well inside the shortest timeout of 65 cycles
      repeat (3) begin
         repeat (DIV / 2) @(posedge clk);
         wr(A_CTRL, 32'hc1, 4'hf);
      end
      check("refreshed", 32'(req_cnt), 32'h0);
      n = 0;
      while (!req && n < 300) begin
         @(posedge clk);
         n++;
      end
      check("timeout", {31'h0, n > DIV && n <= 2 * DIV}, 32'h1);
      rd(A_CTRL);
      check("wrapped", v, 32'hbf);
      check("one_pulse", 32'(req_cnt), 32'h1);
      wr(A_CTRL, 32'h7f, 4'hf);
      check("no_disarm", {31'h0, armed}, 32'h1);
      pulse_halt();
      check("halt_armed", 32'(req_cnt), 32'h2);
      rst();
      check("armed_cleared", {31'h0, armed}, 32'h0);
      wr(A_CTRL, 32'h80, 4'hf);
      repeat (2) @(posedge clk);
      check("forced", 32'(req_cnt), 32'h3);
      rst();
      wr(A_CFG, 32'h1, 4'hf);
      rd(A_CFG);
      check("hw_option", v, 32'h11);
      check("hw_armed", {31'h0, armed}, 32'h1);
      pulse_halt();
      check("halt_opt_off", 32'(req_cnt), 32'h3);
      wr(A_CTRL, 32'h0, 4'hf);
      repeat (2) @(posedge clk);
      check("hw_force", 32'(req_cnt), 32'h4);
      summarize();
   end
endmodule
